// ===== logic/gauge_mode_pkg.sv
//
// Function
// - charge result: two's complement, 6.70 uVh steps
// - current result: two's complement, 11.77 uV steps
// - voltage result: unsigned, 2.44 mV steps
// - mode bit 2 selects power saving
// - mode bit 3 enables alarm function
// - mode bit 4 clear freezes gauge, standby
// - control bit 0 reads alarm pin level
// - control bit 0 write: force alarm low
// - gauge reset clears accumulator, counter, self-clears
// - current conversion done set, clears on read
// - voltage conversion done set, clears on read
// - control bit 4 reads power-on detect
// - bit 4 write sets/clears soft reset, flag
// - low charge flag set by condition, host clears
// - low voltage flag set by condition, host clears
// - re-alarm only after condition goes, returns
// - reset disables alarm, clears thresholds, base, relax
// - run starts voltage first; stop aborts cycle
package gauge_mode_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;  // operating_mode
  localparam logic [7:0] OFS_CTRL = 8'h01;  // control_and_status
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_RSVD  = 1;  // mode reserved bit
  localparam int BIT_PSAVE = 2;  // power_save_select
  localparam int BIT_ALMEN = 3;  // alarm_enable
  localparam int BIT_RUN   = 4;  // gauge_run
  localparam int BIT_PIN   = 0;  // alarm_pin_drive / pin level
  localparam int BIT_GRST  = 1;  // gauge_reset
  localparam int BIT_CDONE = 2;  // current_conv_done
  localparam int BIT_VDONE = 3;  // voltage_conv_done
  localparam int BIT_POR   = 4;  // power_on_detect / soft reset
  localparam int BIT_LSOC  = 5;  // low_charge_alarm_flag
  localparam int BIT_LVOLT = 6;  // low_voltage_alarm_flag
  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'h1e;  // bits 1..4 kept
  localparam logic       DRIVE_RST = 1'b1;   // alarm_pin_drive
  localparam logic       POR_RST   = 1'b1;   // flag set at power-on
  localparam logic       PIN_IDLE  = 1'b1;   // alarm pin level, pulled up
  // ---------------------------------------------------------------
  // result encodings (scale of one step, for documentation)
  // ---------------------------------------------------------------
  localparam real CHARGE_LSB_UVH  = 6.70;   // signed
  localparam real CURRENT_LSB_UV  = 11.77;  // signed
  localparam real VOLTAGE_LSB_MV  = 2.44;   // unsigned
  localparam int  RESULT_W        = 16;
  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,  // standby
    SEQ_VOLT = 3'b010,  // voltage conversion running
    SEQ_CURR = 3'b100   // current conversion running
  } seq_t;
endpackage : gauge_mode_pkg

// ===== logic/gauge_mode_ctrl.sv
module gauge_mode_ctrl
  import gauge_mode_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // register port from the serial slave (same clock)
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWdata,
  output logic      [7:0]            regRdata,
  // analog front end events and results (same clock)
  input  wire logic                  voltConvEnd,
  input  wire logic                  currConvEnd,
  input  wire logic signed [15:0]    chargeIn,
  input  wire logic signed [15:0]    currentIn,
  input  wire logic [15:0]           voltageIn,
  input  wire logic                  lowChargeCond,
  input  wire logic                  lowVoltCond,
  // alarm pin, open drain
  input  wire logic                  alarmPinIn,
  output logic                       alarmPinOe,
  output logic                       alarmPinOut,
  // control to the rest of the gauge
  output logic                       powerSaveSelect,
  output logic                       gaugeRun,
  output logic                       gaugeClear,
  output logic                       convAbort,
  output logic                       startVolt,
  output logic                       startCurr,
  output logic                       softReset,
  output logic                       thresholdClear,
  output logic signed [15:0]         chargeOut,
  output logic signed [15:0]         currentOut,
  output logic [15:0]                voltageOut
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         mode;       // operating_mode bits
    logic               pinDrive;   // alarm_pin_drive
    logic               curDone;    // current_conv_done
    logic               volDone;    // voltage_conv_done
    logic               porFlag;    // power_on_detect
    logic               lowChg;     // low_charge_alarm_flag
    logic               lowVol;     // low_voltage_alarm_flag
    logic               armChg;     // charge alarm may fire
    logic               armVol;     // voltage alarm may fire
    logic               pinS1;      // pin sync stage 1
    logic               pinS2;      // pin sync stage 2
    seq_t               seq;        // conversion sequencer
    logic [7:0]         rdata;      // read data
    logic               clr;        // gauge clear pulse
    logic               abort;      // abort pulse
    logic               goVolt;     // start voltage pulse
    logic               goCurr;     // start current pulse
    logic               pinOe;      // pin pulled low
    logic               thrClr;     // threshold clear pulse
    logic signed [15:0] chg;        // charge result
    logic signed [15:0] cur;        // current result
    logic [15:0]        vol;        // voltage result
  } state_t;

  state_t cur, next_s;

  logic wrMode, wrCtrl, rdCtrl, runNow, alarmActive;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_s = cur;
    // address decode
    wrMode = 1'b0;
    wrCtrl = 1'b0;
    rdCtrl = 1'b0;
    if (regWrite && regAddr == OFS_MODE) begin
      wrMode = 1'b1;
    end else if (regWrite && regAddr == OFS_CTRL) begin
      wrCtrl = 1'b1;
    end
    if (regRead && regAddr == OFS_CTRL) begin
      rdCtrl = 1'b1;
    end
    // pin level passes two flops first
    next_s.pinS1 = alarmPinIn;
    next_s.pinS2 = cur.pinS1;
    // pulses default low
    next_s.clr    = 1'b0;
    next_s.abort  = 1'b0;
    next_s.goVolt = 1'b0;
    next_s.goCurr = 1'b0;
    next_s.thrClr = 1'b0;
    // mode register; bit 1 stored as written, host keeps it 0
    if (wrMode) begin
      next_s.mode = regWdata & MODE_MASK;
    end
    runNow = cur.mode[BIT_RUN];
    // control register write side
    if (wrCtrl) begin
      next_s.pinDrive = regWdata[BIT_PIN];
      if (regWdata[BIT_GRST]) begin
        next_s.clr = 1'b1;
      end
      next_s.porFlag = regWdata[BIT_POR];
      // writing 0 clears, writing 1 leaves the flag alone
      if (!regWdata[BIT_LSOC]) begin
        next_s.lowChg = 1'b0;
      end
      if (!regWdata[BIT_LVOLT]) begin
        next_s.lowVol = 1'b0;
      end
      // soft reset asserted: alarm off, thresholds cleared
      if (regWdata[BIT_POR]) begin
        next_s.mode[BIT_ALMEN] = 1'b0;
        next_s.thrClr          = 1'b1;
      end
    end
    // read clears the done flags; a new event still wins
    if (rdCtrl) begin
      next_s.curDone = 1'b0;
      next_s.volDone = 1'b0;
    end
    if (currConvEnd && runNow && cur.seq == SEQ_CURR) begin
      next_s.curDone = 1'b1;
    end
    if (voltConvEnd && runNow && cur.seq == SEQ_VOLT) begin
      next_s.volDone = 1'b1;
    end
    // alarms: fire once per appearance of the condition
    if (!lowChargeCond) begin
      next_s.armChg = 1'b1;
    end
    if (!lowVoltCond) begin
      next_s.armVol = 1'b1;
    end
    if (cur.mode[BIT_ALMEN] && lowChargeCond && cur.armChg) begin
      next_s.lowChg = 1'b1;
      next_s.armChg = 1'b0;
    end
    if (cur.mode[BIT_ALMEN] && lowVoltCond && cur.armVol) begin
      next_s.lowVol = 1'b1;
      next_s.armVol = 1'b0;
    end
    // conversion sequencer
    case (cur.seq)
      SEQ_IDLE: begin
        if (runNow) begin
          next_s.seq = SEQ_VOLT;
          next_s.goVolt = 1'b1;
        end
      end
      SEQ_VOLT: begin
        if (!runNow) begin
          next_s.seq   = SEQ_IDLE;
          next_s.abort = 1'b1;
        end else if (voltConvEnd) begin
          next_s.seq = SEQ_CURR;
          next_s.goCurr = 1'b1;
        end
      end
      SEQ_CURR: begin
        if (!runNow) begin
          next_s.seq   = SEQ_IDLE;
          next_s.abort = 1'b1;
        end else if (currConvEnd) begin
          next_s.seq = SEQ_VOLT;
          next_s.goVolt = 1'b1;
        end
      end
      default: begin
        next_s.seq = SEQ_IDLE;
      end
    endcase
    // results follow the front end only while running
    if (runNow) begin
      next_s.chg = chargeIn;
      next_s.cur = currentIn;
      next_s.vol = voltageIn;
    end
    if (next_s.clr) begin
      next_s.chg = '0;
    end
    // pin pulled low when forced or an enabled alarm stands
    alarmActive = cur.mode[BIT_ALMEN] && (cur.lowChg || cur.lowVol);
    next_s.pinOe = !cur.pinDrive || alarmActive;
    // read data, registered; unused bits zero
    next_s.rdata = 8'h00;
    if (regRead && regAddr == OFS_MODE) begin
      next_s.rdata = cur.mode & MODE_MASK;
    end else if (rdCtrl) begin
      next_s.rdata[BIT_PIN]   = cur.pinS2;
      next_s.rdata[BIT_CDONE] = cur.curDone;
      next_s.rdata[BIT_VDONE] = cur.volDone;
      next_s.rdata[BIT_POR]   = cur.porFlag;
      next_s.rdata[BIT_LSOC]  = cur.lowChg;
      next_s.rdata[BIT_LVOLT] = cur.lowVol;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cur          <= '0;
      cur.mode     <= MODE_RST;
      cur.pinDrive <= DRIVE_RST;
      cur.porFlag  <= POR_RST;
      cur.armChg   <= 1'b1;
      cur.armVol   <= 1'b1;
      // synchroniser starts at the idle pin level, else a read
      // right after reset would report a low pin that is not there
      cur.pinS1    <= PIN_IDLE;
      cur.pinS2    <= PIN_IDLE;
      cur.seq      <= SEQ_IDLE;
      cur.thrClr   <= 1'b1;
      cur.clr      <= 1'b1;
    end else begin
      cur <= next_s;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all straight from flops except alarmPinOut, tied to 0
  // -----------------------------------------------------------------
  assign regRdata        = cur.rdata;
  assign alarmPinOe      = cur.pinOe;
  assign alarmPinOut     = 1'b0;  // open drain only pulls low
  assign powerSaveSelect = cur.mode[BIT_PSAVE];
  assign gaugeRun        = cur.mode[BIT_RUN];
  assign gaugeClear      = cur.clr;
  assign convAbort       = cur.abort;
  assign startVolt       = cur.goVolt;
  assign startCurr       = cur.goCurr;
  assign softReset       = cur.porFlag;
  assign thresholdClear  = cur.thrClr;
  assign chargeOut       = cur.chg;
  assign currentOut      = cur.cur;
  assign voltageOut      = cur.vol;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_ctrlRead;
    regRead && regAddr == OFS_CTRL && !currConvEnd && !voltConvEnd;
  endsequence

  property p_doneClear;
    @(posedge clk_sys) disable iff (!rst_b)
      s_ctrlRead |=> !cur.curDone && !cur.volDone;
  endproperty
  a_doneClear: assert property (p_doneClear)
    else $error("done flag survived read");

  property p_runFirstVolt;
    @(posedge clk_sys) disable iff (!rst_b)
      (cur.seq == SEQ_IDLE && gaugeRun) |=> startVolt && !startCurr;
  endproperty
  a_runFirstVolt: assert property (p_runFirstVolt)
    else $error("run did not start voltage first");

  property p_abort;
    @(posedge clk_sys) disable iff (!rst_b)
      (cur.seq != SEQ_IDLE && !gaugeRun) |=> convAbort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("stop did not abort");

  property p_frozen;
    @(posedge clk_sys) disable iff (!rst_b)
      (!gaugeRun && !next_s.clr) |=> $stable(chargeOut);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("charge moved in standby");

  property p_gaugeReset;
    @(posedge clk_sys) disable iff (!rst_b)
      (regWrite && regAddr == OFS_CTRL && regWdata[BIT_GRST])
        |=> gaugeClear ##1 (!gaugeClear && chargeOut == 16'sh0000);
  endproperty
  a_gaugeReset: assert property (p_gaugeReset)
    else $error("gauge reset not one pulse");

  property p_forceLow;
    @(posedge clk_sys) disable iff (!rst_b)
      (regWrite && regAddr == OFS_CTRL && !regWdata[BIT_PIN])
        |=> ##1 alarmPinOe;
  endproperty
  a_forceLow: assert property (p_forceLow)
    else $error("alarm pin not forced low");

  property p_porWrite;
    @(posedge clk_sys) disable iff (!rst_b)
      (regWrite && regAddr == OFS_CTRL)
        |=> softReset == $past(regWdata[BIT_POR]);
  endproperty
  a_porWrite: assert property (p_porWrite)
    else $error("soft reset bit wrong");

  property p_modeRead;
    @(posedge clk_sys) disable iff (!rst_b)
      (regRead && regAddr == OFS_MODE) |=> regRdata[7:5] == 3'h0
        && regRdata[0] == 1'b0;
  endproperty
  a_modeRead: assert property (p_modeRead)
    else $error("unused mode bits not zero");

  property p_noRefire;
    @(posedge clk_sys) disable iff (!rst_b)
      (!cur.armChg && lowChargeCond) |=> !cur.armChg;
  endproperty
  a_noRefire: assert property (p_noRefire)
    else $error("charge alarm rearmed early");

  property p_lowChg;
    @(posedge clk_sys) disable iff (!rst_b)
      (cur.mode[BIT_ALMEN] && lowChargeCond && cur.armChg) |=> cur.lowChg;
  endproperty
  a_lowChg: assert property (p_lowChg)
    else $error("low charge flag not set");

  property p_lowVol;
    @(posedge clk_sys) disable iff (!rst_b)
      (cur.mode[BIT_ALMEN] && lowVoltCond && cur.armVol) |=> cur.lowVol;
  endproperty
  a_lowVol: assert property (p_lowVol)
    else $error("low voltage flag not set");

  // soft reset write: alarm off and thresholds cleared next cycle
  property p_softRst;
    @(posedge clk_sys) disable iff (!rst_b)
      (regWrite && regAddr == OFS_CTRL && regWdata[BIT_POR])
        |=> thresholdClear && !cur.mode[BIT_ALMEN];
  endproperty
  a_softRst: assert property (p_softRst)
    else $error("soft reset left alarm enabled");

  // voltage end seen in its own slot raises the done flag
  property p_voltDone;
    @(posedge clk_sys) disable iff (!rst_b)
      (voltConvEnd && gaugeRun && cur.seq == SEQ_VOLT) |=> cur.volDone;
  endproperty
  a_voltDone: assert property (p_voltDone)
    else $error("voltage done flag not set");

  // an enabled, standing alarm flag pulls the pin low
  property p_alarmDrive;
    @(posedge clk_sys) disable iff (!rst_b)
      (cur.mode[BIT_ALMEN] && (cur.lowChg || cur.lowVol)) |=> alarmPinOe;
  endproperty
  a_alarmDrive: assert property (p_alarmDrive)
    else $error("alarm flag did not pull pin low");
endmodule : gauge_mode_ctrl

// ===== tb/gauge_front_model.sv
module gauge_front_model #(
  parameter int CONV_CYC = 4  // conversion length, kept short
) (
  input  wire logic clk_sys,
  input  wire logic startVolt,
  input  wire logic startCurr,
  input  wire logic convAbort,
  input  wire logic alarmPinOe,
  output logic      voltConvEnd,
  output logic      currConvEnd,
  output wire logic alarmPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // analog front end stand-in
  // ---------------------------------------------------------------
  int left   = 0;     // cycles to conversion end, 0 when idle
  bit isVolt = 1'b0;  // kind of the running conversion
  // open-drain pin with pull-up: never floats
  assign alarmPinIn = alarmPinOe ? 1'b0 : 1'b1;
  initial begin
    voltConvEnd = 1'b0;
    currConvEnd = 1'b0;
  end
  // end pulses last one cycle; abort wins over a pending end
  always @(negedge clk_sys) begin
    voltConvEnd <= 1'b0;
    currConvEnd <= 1'b0;
    if (convAbort) begin
      left <= 0;
    end else if (startVolt || startCurr) begin
      left   <= CONV_CYC;
      isVolt <= startVolt;
    end else if (left == 1) begin
      voltConvEnd <= isVolt;
      currConvEnd <= !isVolt;
      left        <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule : gauge_front_model

// ===== tb/test_battery_monitor_mode_control.sv
module test_battery_monitor_mode_control
  import gauge_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd;
  logic voltConvEnd, currConvEnd, alarmPinIn, alarmPinOe;
  logic signed [15:0] chargeIn = 16'h0000, currentIn = 16'h0000;
  logic signed [15:0] chargeOut, currentOut;
  logic [15:0] voltageIn = 16'h0000, voltageOut;
  logic [1:0] conds = 2'h0;  // low charge, low voltage
  logic powerSaveSelect, gaugeRun, gaugeClear, convAbort, startVolt;
  logic startCurr, softReset, thresholdClear, pinOut;
  int fails = 0, checked = 0, cyc = 0;
  // one-cycle pulses, watched by index
  wire logic [4:0] pulses = {thresholdClear, convAbort, startCurr,
                             startVolt, gaugeClear};
  always #2.5 clk_sys = ~clk_sys;  // 200 MHz
  // ---------------------------------------------------------------
  // device and front end
  // ---------------------------------------------------------------
  gauge_mode_ctrl dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata),
    .voltConvEnd(voltConvEnd), .currConvEnd(currConvEnd),
    .chargeIn(chargeIn), .currentIn(currentIn), .voltageIn(voltageIn),
    .lowChargeCond(conds[0]), .lowVoltCond(conds[1]),
    .alarmPinIn(alarmPinIn), .alarmPinOe(alarmPinOe), .alarmPinOut(pinOut),
    .powerSaveSelect(powerSaveSelect), .gaugeRun(gaugeRun),
    .gaugeClear(gaugeClear), .convAbort(convAbort),
    .startVolt(startVolt), .startCurr(startCurr), .softReset(softReset),
    .thresholdClear(thresholdClear), .chargeOut(chargeOut),
    .currentOut(currentOut), .voltageOut(voltageOut));
  gauge_front_model #(.CONV_CYC(4)) front_u (.clk_sys(clk_sys),
    .startVolt(startVolt), .startCurr(startCurr), .convAbort(convAbort),
    .alarmPinOe(alarmPinOe), .voltConvEnd(voltConvEnd),
    .currConvEnd(currConvEnd), .alarmPinIn(alarmPinIn));
  // ---------------------------------------------------------------
  // access and compare tasks, all entered at a falling edge
  // ---------------------------------------------------------------
  task chk(input string name, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      $display("BAD %s exp %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : chk
  task wr(input logic [7:0] a, d);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
  endtask : wr
  // read data stands one cycle after the read edge
  task rdChk(input logic [7:0] a, exp, input string name);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    chk(name, {8'h00, regRdata}, {8'h00, exp});
  endtask : rdChk
  // bounded wait, a missing pulse is a mismatch
  task waitPulse(input int idx, input string name);
    int n;
    n = 0;
    while (pulses[idx] !== 1'b1 && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    chk(name, {15'h0, pulses[idx]}, 16'h1);
  endtask : waitPulse
  // pin level crosses a two-flop synchroniser
  task settle();
    repeat (4) @(negedge clk_sys);
  endtask : settle
  task results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // ---------------------------------------------------------------
  // hang guard, tests need well under 1000 cycles
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    chk("thr rst", {15'h0, thresholdClear}, 16'h1);
    chk("clr rst", {15'h0, gaugeClear}, 16'h1);
    rdChk(OFS_MODE, 8'h00, "mode rst");
    rdChk(OFS_CTRL, 8'h11, "ctrl rst");
    chk("run rst", {15'h0, gaugeRun}, 16'h0);
    $display("test reset done");
    wr(OFS_MODE, 8'hfd);
    rdChk(OFS_MODE, 8'h1c, "mode mask");
    chk("psave", {15'h0, powerSaveSelect}, 16'h1);
    wr(OFS_MODE, 8'h00);
    chk("psave off", {15'h0, powerSaveSelect}, 16'h0);
    rdChk(8'h02, 8'h00, "no reg");
    $display("test mode done");
    wr(OFS_CTRL, 8'h11);
    chk("soft on", {15'h0, softReset}, 16'h1);
    waitPulse(4, "thr clr");
    rdChk(OFS_CTRL, 8'h11, "por set");
    wr(OFS_CTRL, 8'h01);
    rdChk(OFS_CTRL, 8'h01, "por clr");
    chk("soft off", {15'h0, softReset}, 16'h0);
    $display("test soft reset done");
    wr(OFS_CTRL, 8'h00);
    settle();
    rdChk(OFS_CTRL, 8'h00, "pin low");
    chk("pin out", {15'h0, pinOut}, 16'h0);
    wr(OFS_CTRL, 8'h01);
    settle();
    rdChk(OFS_CTRL, 8'h01, "pin high");
    $display("test pin done");
    chargeIn  = 16'sh8001;
    currentIn = 16'shfff0;
    voltageIn = 16'hc350;
    wr(OFS_MODE, 8'h10);
    waitPulse(1, "volt first");
    waitPulse(2, "curr next");
    repeat (6) @(negedge clk_sys);
    chk("charge", chargeOut, 16'h8001);
    chk("current", currentOut, 16'hfff0);
    chk("voltage", voltageOut, 16'hc350);
    wr(OFS_MODE, 8'h00);
    waitPulse(3, "abort");
    chargeIn = 16'sh0005;
    repeat (3) @(negedge clk_sys);
    chk("frozen", chargeOut, 16'h8001);
    rdChk(OFS_CTRL, 8'h0d, "eoc set");
    rdChk(OFS_CTRL, 8'h01, "eoc clr");
    $display("test run done");
    wr(OFS_CTRL, 8'h03);
    waitPulse(0, "gauge clr");
    @(negedge clk_sys);
    chk("charge clr", chargeOut, 16'h0000);
    rdChk(OFS_CTRL, 8'h01, "grst self");
    $display("test gauge reset done");
    conds = 2'h3;
    settle();
    rdChk(OFS_CTRL, 8'h01, "alm off");
    conds = 2'h0;
    wr(OFS_MODE, 8'h08);
    for (int k = 0; k < 2; k++) begin
      conds[k] = 1'b1;
      settle();
      rdChk(OFS_CTRL, 8'h20 << k, "alm set");
      wr(OFS_CTRL, 8'h01);
      settle();
      rdChk(OFS_CTRL, 8'h01, "alm held");
      conds[k] = 1'b0;
      @(negedge clk_sys);
      conds[k] = 1'b1;
      settle();
      rdChk(OFS_CTRL, 8'h20 << k, "alm again");
      conds[k] = 1'b0;
      wr(OFS_CTRL, 8'h01);
      settle();
      rdChk(OFS_CTRL, 8'h01, "alm clr");
    end
    $display("test alarm done");
    results();
  end
endmodule : test_battery_monitor_mode_control
